// *** rtl/ipr_defs.svh ***
// constants of the interrupt priority resolver
`ifndef IPR_DEFS_SVH
`define IPR_DEFS_SVH

// source count and rank index of each group start
`define IPR_NUM_SRC 42
`define IPR_NUM_L3 6
`define IPR_IDX_RESET 0
`define IPR_IDX_NMI 5
`define IPR_IDX_PIN 6
`define IPR_IDX_DMA 10
`define IPR_IDX_HOST 16
`define IPR_IDX_SSP0 19
`define IPR_IDX_SSP1 25
`define IPR_IDX_ASYNC 31
`define IPR_IDX_TMR 36

// maskable group numbers inside core_priority_config
`define IPR_NUM_GRP 10
`define IPR_GRP_DMA 4
`define IPR_GRP_HOST 5
`define IPR_GRP_SSP0 6
`define IPR_GRP_SSP1 7
`define IPR_GRP_ASYNC 8
`define IPR_GRP_TMR 9

// levels
`define IPR_LVL_NMI 2'h3
`define IPR_LVL_RST 2'h0

// vector table offsets, rank order, entry 41 first
`define IPR_OFF_TABLE { \
  8'h2C, 8'h2E, 8'h28, 8'h2A, 8'h24, 8'h26, \
  8'h58, 8'h56, 8'h54, 8'h50, 8'h52, \
  8'h46, 8'h4A, 8'h48, 8'h44, 8'h40, 8'h42, \
  8'h36, 8'h3A, 8'h38, 8'h34, 8'h30, 8'h32, \
  8'h60, 8'h62, 8'h64, \
  8'h22, 8'h20, 8'h1E, 8'h1C, 8'h1A, 8'h18, \
  8'h16, 8'h14, 8'h12, 8'h10, \
  8'h0A, 8'h08, 8'h06, 8'h04, 8'h02, 8'h00}
`define IPR_OFF_DMA0 8'h18

`endif

// *** rtl/ipr_pin_detect.sv ***
// synchroniser and level or falling edge detector for one request pin
`timescale 1ns/100ps
`include "ipr_defs.svh"
module ipr_pin_detect
  import ipr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_n,
  input wire logic edge_mode,
  input wire logic clear,
  output logic request
);

  logic sync1;
  logic sync2;
  logic prev;
  logic latched;
  logic fall;

  // ==========================================
  // two-flop synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      prev <= 1'b1;
    end else begin
      sync1 <= pin_n;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  assign fall = prev && !sync2;

  // ==========================================
  // edge latch, set beats clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched <= 1'b0;
    end else if (!edge_mode) begin
      latched <= 1'b0;
    end else if (fall) begin
      latched <= 1'b1;
    end else if (clear) begin
      latched <= 1'b0;
    end
  end

  assign request = edge_mode ? latched : !sync2;

  // ==========================================
  // checks
  a_edge_caught: assert property (@(posedge clk) disable iff (!rst_n)
    edge_mode && fall |=> request)
    else $error("falling edge not latched");
  a_edge_held: assert property (@(posedge clk) disable iff (!rst_n)
    edge_mode && request && !clear |=> request || !edge_mode)
    else $error("edge request lost before service");

endmodule

// *** rtl/ipr_pkg.sv ***
// types of the interrupt priority resolver
package ipr_pkg;
  typedef logic [1:0] ipr_lvl_t;
  typedef logic [5:0] ipr_src_t;
  typedef logic [7:0] ipr_off_t;
endpackage

// *** rtl/ipr_resolver.sv ***
// interrupt priority resolver: picks the request the core services next
// Function
// - at each instruction boundary the pending source with the highest level wins.
// - ties in level are broken by a fixed, non-programmable source ranking.
// - requests below the two-bit core mask level are ignored.
// - level 3 ranks reset, stack error, illegal, debug, trap, nmi pin.
// - in maskable levels, external pins A, B, C, D rank first.
// - dma channels 0 to 5 rank directly below the pins.
// - host command, transmit empty, receive full follow dma channel 5.
// - serial port 0: rx exception, rx, rx last, tx exception, tx last, tx.
// - serial port 1 follows with the same six-entry order.
// - async serial: rx exception, rx, tx, idle line, timer.
// - timers rank last: unit overflow before compare, units 0, 1, 2.
// - pin request is level when its trigger bit is 0, falling edge when 1.
// - vector is vector base plus the source's fixed even offset.
`timescale 1ns/100ps
`include "ipr_defs.svh"
module ipr_resolver
  import ipr_pkg::*;
#(
  parameter int NSRC = `IPR_NUM_SRC,
  parameter int VW = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic insn_boundary,
  input wire logic [1:0] core_mask,
  input wire logic [VW-1:0] vector_base,
  input wire logic hw_reset_request,
  input wire logic stack_error_request,
  input wire logic illegal_insn_request,
  input wire logic debug_request,
  input wire logic trap_request,
  input wire logic nmi_pin_n,
  input wire logic ext_pin_request_a_n,
  input wire logic ext_pin_request_b_n,
  input wire logic ext_pin_request_c_n,
  input wire logic ext_pin_request_d_n,
  input wire logic [3:0] pin_trigger_mode_bit,
  input wire logic [19:0] core_priority_config,
  input wire logic [9:0] group_enable,
  input wire logic [5:0] dma_request,
  input wire logic [2:0] host_request,
  input wire logic [5:0] sync_serial_port0_request,
  input wire logic [5:0] sync_serial_port1_request,
  input wire logic [4:0] async_serial_iface_request,
  input wire logic [5:0] timer_unit_request,
  output logic irq_take,
  output ipr_src_t irq_source,
  output ipr_lvl_t irq_level,
  output logic [VW-1:0] irq_vector
);

  localparam logic [NSRC*8-1:0] OFF_TABLE = `IPR_OFF_TABLE;

  logic rst_q1;
  logic rst_sync_n;
  logic [3:0] pin_req;
  logic [3:0] pin_clear;
  logic nmi_req;
  logic nmi_clear;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] elig;
  ipr_lvl_t src_lvl [NSRC];
  logic src_en [NSRC];
  logic next_found;
  ipr_src_t next_win;
  ipr_lvl_t next_lvl;
  logic take_now;
  logic pref_hit;

  // ==========================================
  // reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_sync_n <= rst_q1;
    end
  end

  // ==========================================
  // external pins, one detector each
  ipr_pin_detect u_pin_a (
    .clk(clk), .rst_n(rst_sync_n), .pin_n(ext_pin_request_a_n),
    .edge_mode(pin_trigger_mode_bit[0]), .clear(pin_clear[0]), .request(pin_req[0]));
  ipr_pin_detect u_pin_b (
    .clk(clk), .rst_n(rst_sync_n), .pin_n(ext_pin_request_b_n),
    .edge_mode(pin_trigger_mode_bit[1]), .clear(pin_clear[1]), .request(pin_req[1]));
  ipr_pin_detect u_pin_c (
    .clk(clk), .rst_n(rst_sync_n), .pin_n(ext_pin_request_c_n),
    .edge_mode(pin_trigger_mode_bit[2]), .clear(pin_clear[2]), .request(pin_req[2]));
  ipr_pin_detect u_pin_d (
    .clk(clk), .rst_n(rst_sync_n), .pin_n(ext_pin_request_d_n),
    .edge_mode(pin_trigger_mode_bit[3]), .clear(pin_clear[3]), .request(pin_req[3]));
  // nmi pin is always edge triggered
  ipr_pin_detect u_pin_nmi (
    .clk(clk), .rst_n(rst_sync_n), .pin_n(nmi_pin_n),
    .edge_mode(1'b1), .clear(nmi_clear), .request(nmi_req));

  // ==========================================
  // pending vector in fixed rank order, bit 0 highest
  always_comb begin
    pend[`IPR_IDX_PIN-1:0] = {nmi_req, trap_request, debug_request,
      illegal_insn_request, stack_error_request, hw_reset_request};
    pend[`IPR_IDX_DMA-1:`IPR_IDX_PIN] = pin_req;
    pend[`IPR_IDX_HOST-1:`IPR_IDX_DMA] = dma_request;
    // host cmd, tx empty, rx full
    pend[`IPR_IDX_SSP0-1:`IPR_IDX_HOST] = host_request;
    pend[`IPR_IDX_SSP1-1:`IPR_IDX_SSP0] = sync_serial_port0_request;
    pend[`IPR_IDX_ASYNC-1:`IPR_IDX_SSP1] = sync_serial_port1_request;
    pend[`IPR_IDX_TMR-1:`IPR_IDX_ASYNC] = async_serial_iface_request;
    pend[NSRC-1:`IPR_IDX_TMR] = timer_unit_request;
  end

  // ==========================================
  // level and enable of each maskable source from its group; level 3 sources fixed and always enabled
  always_comb begin
    int g;
    g = 0;
    for (int i = 0; i < NSRC; i++) begin
      if (i < `IPR_NUM_L3) g = 0;
      else if (i < `IPR_IDX_DMA) g = i - `IPR_IDX_PIN;
      else if (i < `IPR_IDX_HOST) g = `IPR_GRP_DMA;
      else if (i < `IPR_IDX_SSP0) g = `IPR_GRP_HOST;
      else if (i < `IPR_IDX_SSP1) g = `IPR_GRP_SSP0;
      else if (i < `IPR_IDX_ASYNC) g = `IPR_GRP_SSP1;
      else if (i < `IPR_IDX_TMR) g = `IPR_GRP_ASYNC;
      else g = `IPR_GRP_TMR;
      if (i < `IPR_NUM_L3) begin
        src_lvl[i] = `IPR_LVL_NMI;
        src_en[i] = 1'b1;
      end else begin
        src_lvl[i] = core_priority_config[g*2 +: 2];
        src_en[i] = group_enable[g];
      end
    end
  end

  // ==========================================
  // mask filter, level 3 exempt
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      elig[i] = pend[i] && src_en[i] &&
        ((i < `IPR_NUM_L3) || (src_lvl[i] >= core_mask));
    end
  end

  // ==========================================
  // highest level first
  // first in rank wins a tie
  always_comb begin
    next_found = 1'b0;
    next_win = '0;
    next_lvl = `IPR_LVL_RST;
    for (int i = 0; i < NSRC; i++) begin
      if (elig[i] && (!next_found || src_lvl[i] > next_lvl)) begin
        next_found = 1'b1;
        next_win = ipr_src_t'(i);
        next_lvl = src_lvl[i];
      end
    end
  end

  assign take_now = insn_boundary && next_found;

  // clear edge latches of the serviced pin
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      pin_clear[k] = take_now && (next_win == ipr_src_t'(`IPR_IDX_PIN + k));
    end
    nmi_clear = take_now && (next_win == ipr_src_t'(`IPR_IDX_NMI));
  end

  // ==========================================
  // take pulse and winner outputs
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_take <= 1'b0;
    end else begin
      irq_take <= take_now;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_source <= '0;
      irq_level <= `IPR_LVL_RST;
      irq_vector <= '0;
    end else if (take_now) begin
      irq_source <= next_win;
      irq_level <= next_lvl;
      irq_vector <= vector_base + VW'(OFF_TABLE[next_win*8 +: 8]);
    end
  end

  // ==========================================
  // checks and helper
  always_comb begin
    pref_hit = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (ipr_src_t'(i) < next_win && elig[i] && src_lvl[i] == next_lvl) pref_hit = 1'b1;
    end
  end

  a_take_boundary: assert property (@(posedge clk) disable iff (!rst_sync_n)
    irq_take |-> $past(insn_boundary))
    else $error("take without instruction boundary");
  a_l3_preempts: assert property (@(posedge clk) disable iff (!rst_sync_n)
    insn_boundary && (|pend[`IPR_NUM_L3-1:0]) |=> irq_take && irq_level == `IPR_LVL_NMI)
    else $error("level 3 request not taken first");
  a_rank_tie: assert property (@(posedge clk) disable iff (!rst_sync_n)
    take_now |-> !pref_hit)
    else $error("lower ranked source won a tie");
  a_mask_blocks: assert property (@(posedge clk) disable iff (!rst_sync_n)
    irq_take && irq_source >= ipr_src_t'(`IPR_NUM_L3) |-> irq_level >= $past(core_mask))
    else $error("masked level was serviced");
  a_reset_first: assert property (@(posedge clk) disable iff (!rst_sync_n)
    insn_boundary && hw_reset_request |=> irq_source == ipr_src_t'(`IPR_IDX_RESET))
    else $error("reset request did not win");
  a_pin_over_dma: assert property (@(posedge clk) disable iff (!rst_sync_n)
    take_now && next_win == ipr_src_t'(`IPR_IDX_DMA) |-> !(elig[`IPR_IDX_PIN] &&
      src_lvl[`IPR_IDX_PIN] == src_lvl[`IPR_IDX_DMA]))
    else $error("dma beat pin a at same level");
  a_vector_dma0: assert property (@(posedge clk) disable iff (!rst_sync_n)
    irq_take && irq_source == ipr_src_t'(`IPR_IDX_DMA) |->
      irq_vector == $past(vector_base) + VW'(`IPR_OFF_DMA0))
    else $error("dma 0 vector wrong");
  a_take_pulse: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !take_now |=> !irq_take && $stable(irq_source) && $stable(irq_vector))
    else $error("outputs moved without a winning boundary");

  c_take_l3: cover property (@(posedge clk) disable iff (!rst_sync_n)
    irq_take && irq_level == `IPR_LVL_NMI);
  c_take_pin: cover property (@(posedge clk) disable iff (!rst_sync_n)
    irq_take && irq_source == ipr_src_t'(`IPR_IDX_PIN));
  c_take_timer: cover property (@(posedge clk) disable iff (!rst_sync_n)
    irq_take && irq_source == ipr_src_t'(NSRC - 1));
  c_all_masked: cover property (@(posedge clk) disable iff (!rst_sync_n)
    insn_boundary && (|pend) && !next_found);

endmodule

// *** sim/ipr_core_model.sv ***
// core sequencer model: raises the boundary strobe and reports the take
`timescale 1ns/100ps
module ipr_core_model
  import ipr_pkg::*;
(
  input wire logic clk,
  input wire logic irq_take,
  output logic insn_boundary
);
  // ==========================================
  // boundary strobe
  initial insn_boundary = 1'b0;

  // one boundary cycle; the take pulse is sampled in the cycle after it
  task automatic arbitrate(output logic took);
    @(posedge clk) #1;
    insn_boundary = 1'b1;
    @(posedge clk) #1;
    insn_boundary = 1'b0;
    took = irq_take;
  endtask
endmodule

// *** sim/tb.sv ***
// self-checking bench of the interrupt priority resolver
`timescale 1ns/100ps
`include "ipr_defs.svh"
module tb
  import ipr_pkg::*;
;
  // ==========================================
  // stimulus and observed signals
  localparam logic [335:0] OFFS = `IPR_OFF_TABLE;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] core_mask = 2'h0;
  logic [23:0] vector_base = 24'h00_1000;
  logic [41:0] req = '0;
  logic [3:0] trig = 4'h0;
  logic [19:0] prio = 20'h0_0000;
  logic [9:0] grp_en = 10'h3FF;
  logic insn_boundary;
  logic irq_take;
  ipr_src_t irq_source;
  ipr_lvl_t irq_level;
  logic [23:0] irq_vector;
  int failures = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  ipr_core_model core_u (
    .clk(clk),
    .irq_take(irq_take),
    .insn_boundary(insn_boundary)
  );

  ipr_resolver dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .insn_boundary(insn_boundary),
    .core_mask(core_mask),
    .vector_base(vector_base),
    .hw_reset_request(req[0]),
    .stack_error_request(req[1]),
    .illegal_insn_request(req[2]),
    .debug_request(req[3]),
    .trap_request(req[4]),
    .nmi_pin_n(~req[5]),
    .ext_pin_request_a_n(~req[6]),
    .ext_pin_request_b_n(~req[7]),
    .ext_pin_request_c_n(~req[8]),
    .ext_pin_request_d_n(~req[9]),
    .pin_trigger_mode_bit(trig),
    .core_priority_config(prio),
    .group_enable(grp_en),
    .dma_request(req[15:10]),
    .host_request(req[18:16]),
    .sync_serial_port0_request(req[24:19]),
    .sync_serial_port1_request(req[30:25]),
    .async_serial_iface_request(req[35:31]),
    .timer_unit_request(req[41:36]),
    .irq_take(irq_take),
    .irq_source(irq_source),
    .irq_level(irq_level),
    .irq_vector(irq_vector)
  );

  // ==========================================
  // shared tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one boundary; winner, level and vector checked when a take is due
  task automatic arb(input logic exp_take, input int idx, input ipr_lvl_t lvl);
    logic took;
    core_u.arbitrate(took);
    chk({23'h0, took}, {23'h0, exp_take}, "take");
    if (exp_take) begin
      chk({18'h0, irq_source}, idx[23:0], "source");
      chk({22'h0, irq_level}, {22'h0, lvl}, "level");
      chk(irq_vector, vector_base + {16'h0, OFFS[8*idx+:8]}, "vector");
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================
  // scenarios
  task automatic t_walk();
    prio = {10{2'h2}};
    req[10] = 1'b1;
    idle(1);
    arb(1'b1, 10, 2'h2); // dma winner
    grp_en[4] = 1'b0;
    arb(1'b0, 0, 2'h0); // disabled group waits
    grp_en[4] = 1'b1;
    arb(1'b1, 10, 2'h2); // still pending after enable
    req[10] = 1'b0;
    idle(1);
    arb(1'b0, 0, 2'h0); // withdrawn request
    $display("walk done");
  endtask

  task automatic t_level();
    prio = {2'h2, {9{2'h1}}};
    req[6] = 1'b1;
    req[41] = 1'b1;
    idle(4);
    arb(1'b1, 41, 2'h2); // higher level wins
    req[41] = 1'b0;
    core_mask = 2'h2;
    arb(1'b0, 0, 2'h0); // below mask ignored
    core_mask = 2'h1;
    arb(1'b1, 6, 2'h1); // still pending
    core_mask = 2'h3;
    arb(1'b0, 0, 2'h0); // mask three
    req[4] = 1'b1;
    arb(1'b1, 4, 2'h3); // level three unmasked
    req = '0;
    core_mask = 2'h0;
    idle(4);
    $display("level and mask done");
  endtask

  // requests are added from the bottom up, so each new one must win
  task automatic t_rank();
    prio = {10{2'h1}};
    for (int i = 41; i >= 0; i--) begin
      req[i] = 1'b1;
      idle(4);
      arb(1'b1, i, (i < 6) ? 2'h3 : 2'h1);
    end
    req = '0;
    idle(4);
    $display("ranking done");
  endtask

  task automatic t_edge();
    trig = 4'h1;
    req[6] = 1'b1;
    idle(4);
    req[6] = 1'b0;
    idle(4);
    arb(1'b1, 6, 2'h1); // edge latched after release
    arb(1'b0, 0, 2'h0); // latch cleared by take
    trig = 4'h0;
    req[6] = 1'b1;
    idle(4);
    arb(1'b1, 6, 2'h1); // level mode pending
    arb(1'b1, 6, 2'h1); // level mode stays
    req[6] = 1'b0;
    idle(4);
    $display("pin trigger done");
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    idle(3);
    t_walk();
    t_level();
    t_rank();
    t_edge();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule
